// ===== logic/cqm_pkg.sv
`default_nettype none
package cqm_pkg;
  localparam int          AXI_AW           = 8;
  localparam int          SAMPLE_W         = 9;
  localparam int          ERR_W            = 13;
  localparam int          FRAC_W           = 15;
  localparam int          ACC_W            = ERR_W + FRAC_W;
  localparam int          MSE_W            = 9;
  localparam int          IDX_W            = 3;
  localparam int          NUM_THRESH       = 8;

  // Slicer references, decision points and error limits
  localparam int          REF_OUTER        = 128;
  localparam int          REF_INNER_1000   = 64;
  localparam int          DEC_100          = 64;
  localparam int          DEC_OUTER_1000   = 96;
  localparam int          DEC_INNER_1000   = 32;
  localparam int          ERR_MAX_100      = 64;
  localparam int          ERR_MAX_1000     = 32;
  localparam logic [MSE_W-1:0] MSE_MAX     = 9'h1FF;

  // Snapshot period: 1.0 ms at the 125 Msymbol/s receive rate
  localparam int          SNAP_PERIOD_US   = 1000;
  localparam int          SYMBOL_RATE_MHZ  = 125;
  localparam int          SNAP_SYMBOLS     = SNAP_PERIOD_US * SYMBOL_RATE_MHZ;

  // Register byte offsets
  localparam logic [AXI_AW-1:0] OFS_CONFIG   = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_MSE      = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_MSE_WC   = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_QUALITY  = 8'h0C;
  localparam logic [AXI_AW-1:0] OFS_MEAN_ERR = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_STATUS   = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_THRESH   = 8'h20;

  // Register field positions
  localparam int          CFG_ENABLE       = 0;
  localparam int          CFG_SQUARE       = 1;
  localparam int          CFG_CAPTURE      = 2;
  localparam int          CFG_PAIR_LSB     = 4;
  localparam int          CFG_GAIN_LSB     = 8;
  localparam int          CFG_SCALE_LSB    = 12;
  localparam int          QUAL_WORST_LSB   = 4;
  localparam int          TH_HI_LSB        = 16;

  // Reset values
  localparam logic [3:0]  GAIN_RST         = 4'h4;
  localparam logic [3:0]  SCALE_RST        = 4'h0;
  localparam logic [MSE_W-1:0] TH_RST [NUM_THRESH] = '{
    9'h1FF, 9'h100, 9'h0C0, 9'h090, 9'h060, 9'h040, 9'h020, 9'h010
  };

  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage
`default_nettype wire

// ===== logic/cqm_pair_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cqm_pair_if;
  import cqm_pkg::*;
  logic             enable;
  logic             sample_stb;
  logic             tick;
  logic [ERR_W-1:0] cond_err;
  logic [3:0]       gain;
  logic [3:0]       scale;
  logic [ERR_W-1:0] snap;
  logic [MSE_W-1:0] mse;
  modport ctrl (output enable, sample_stb, tick, cond_err, gain, scale, input snap, mse);
  modport filt (input enable, sample_stb, tick, cond_err, gain, scale, output snap, mse);
endinterface
`default_nettype wire

// ===== logic/cqm_pair_filter.sv
`timescale 1ns/100ps
`default_nettype none
module cqm_pair_filter
  import cqm_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  cqm_pair_if.filt  pif
);
  logic        [ACC_W-1:0] acc_r;
  logic        [ERR_W-1:0] snap_r;
  logic signed [ACC_W:0]   diff;
  logic signed [ACC_W:0]   step;
  logic        [ACC_W-1:0] acc_nxt;
  logic        [ERR_W-1:0] scaled;

  // Fraction bits keep small steps from vanishing at large gain shifts
  assign diff    = $signed({1'b0, pif.cond_err, {FRAC_W{1'b0}}}) - $signed({1'b0, acc_r});
  assign step    = diff >>> pif.gain;
  assign acc_nxt = ACC_W'($signed({1'b0, acc_r}) + step);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r  <= '0;
      snap_r <= '0;
    end else if (ce) begin
      if (!pif.enable) begin
        acc_r  <= '0;
        snap_r <= '0;
      end else begin
        if (pif.sample_stb) acc_r <= acc_nxt;
        if (pif.tick) snap_r <= acc_r[ACC_W-1 -: ERR_W];
      end
    end
  end

  assign scaled   = snap_r >> pif.scale;
  assign pif.snap = snap_r;
  assign pif.mse  = (scaled > ERR_W'(MSE_MAX)) ? MSE_MAX : scaled[MSE_W-1:0];
endmodule
`default_nettype wire

// ===== logic/cqm_monitor.sv
// Summary of operation
// - Received levels are sliced onto references -128/0/128 at 100M and -128/-64/0/64/128 at 1000M.
// - Decision points sit midway: -64/64 at 100M, -96/-32/32/96 at 1000M.
// - Slicer error magnitude is limited to 32 at 1000M and 64 at 100M.
// - Each sample adds the difference of conditioned error and filter value; 1000M errors are doubled.
// - Square mode squares the scaled error, otherwise the absolute error is filtered.
// - The added difference is divided by two to the filter gain shift.
// - The MSE figure is the filtered value shifted by the output scale, saturating at 511.
// - The filtered value is snapshot every 125,000 symbols (1.0 ms); results use the snapshot.
// - Writing capture with a pair number loads that pair's result; capture reads back as zero.
// - The largest MSE since the last read of the MSE result is kept as a worst case.
// - MSE maps to a 0..7 quality index through thresholds, 7 at or below threshold six; threshold seven is not used.
// - The lowest quality index since the previous read is reported as a worst case.
// - In absolute mode a capture loads the mean slicer error result instead of the MSE and quality results.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module cqm_monitor
  import cqm_pkg::*;
#(
  parameter int NUM_PAIRS    = 4,
  parameter int SNAP_COUNT   = SNAP_SYMBOLS
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          ce,
  input  wire logic                          symbol_valid,
  input  wire logic [NUM_PAIRS*SAMPLE_W-1:0] symbol_data,
  input  wire logic                          speed_1000,
  input  wire logic [AXI_AW-1:0]             s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [AXI_AW-1:0]             s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);
  localparam int PAIR_W = 2;
  localparam int CNT_W  = $clog2(SNAP_COUNT + 1);

  if (NUM_PAIRS < 1 || NUM_PAIRS > (1 << PAIR_W)) begin : g_chk_pairs
    $error("NUM_PAIRS must be 1 to 4");
  end
  if (SNAP_COUNT < 2) begin : g_chk_snap
    $error("SNAP_COUNT must be at least 2");
  end

  function automatic logic [IDX_W-1:0] quality_index(input logic [MSE_W-1:0] mse,
                                                     input logic [MSE_W-1:0] th [NUM_THRESH]);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int n = 1; n < NUM_THRESH; n++) begin
      if (mse <= th[n-1]) idx = IDX_W'(n);
    end
    return idx;
  endfunction

  function automatic logic [ERR_W-1:0] condition(input logic signed [SAMPLE_W-1:0] x,
                                                 input logic fast,
                                                 input logic square);
    logic signed [SAMPLE_W+1:0] ref_lvl;
    logic signed [SAMPLE_W+1:0] err;
    logic        [6:0]          mag;
    logic        [6:0]          lim;
    ref_lvl = '0;
    if (fast) begin
      if (x > DEC_OUTER_1000) ref_lvl = (SAMPLE_W+2)'(REF_OUTER);
      else if (x > DEC_INNER_1000) ref_lvl = (SAMPLE_W+2)'(REF_INNER_1000);
      else if (x < -DEC_OUTER_1000) ref_lvl = (SAMPLE_W+2)'(-REF_OUTER);
      else if (x < -DEC_INNER_1000) ref_lvl = (SAMPLE_W+2)'(-REF_INNER_1000);
    end else begin
      if (x > DEC_100) ref_lvl = (SAMPLE_W+2)'(REF_OUTER);
      else if (x < -DEC_100) ref_lvl = (SAMPLE_W+2)'(-REF_OUTER);
    end
    err = x - ref_lvl;
    lim = fast ? 7'(ERR_MAX_1000) : 7'(ERR_MAX_100);
    if (err < 0) err = -err;
    // Outer levels have no far neighbour, so overshoot beyond them is clipped
    mag = (err > lim) ? lim : 7'(err);
    if (fast) mag = 7'(mag << 1);
    // Widen before squaring so the product keeps all of its bits
    return square ? ERR_W'(mag) * ERR_W'(mag) : ERR_W'(mag);
  endfunction

  logic                 enable_r;
  logic                 square_r;
  logic [PAIR_W-1:0]    pair_r;
  logic [3:0]           gain_r;
  logic [3:0]           scale_r;
  logic [MSE_W-1:0]     th_r [NUM_THRESH];
  logic [MSE_W-1:0]     mse_res_r;
  logic [MSE_W-1:0]     mse_wc_res_r;
  logic [IDX_W-1:0]     idx_res_r;
  logic [IDX_W-1:0]     idx_wc_res_r;
  logic [ERR_W-1:0]     mean_res_r;
  logic [MSE_W-1:0]     wc_mse_r [NUM_PAIRS];
  logic [IDX_W-1:0]     wc_idx_r [NUM_PAIRS];
  logic [MSE_W-1:0]     cur_mse  [NUM_PAIRS];
  logic [IDX_W-1:0]     cur_idx  [NUM_PAIRS];
  logic [ERR_W-1:0]     cur_snap [NUM_PAIRS];
  logic [CNT_W-1:0]     sym_cnt_r;
  logic                 tick;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;
  logic                 rvalid_r;
  logic [1:0]           rresp_r;
  logic [31:0]          rdata_r;

  // Symbol counter for the snapshot period
  assign tick = ce && enable_r && symbol_valid && (sym_cnt_r == CNT_W'(SNAP_COUNT - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sym_cnt_r <= '0;
    end else if (ce) begin
      if (!enable_r) sym_cnt_r <= '0;
      else if (tick) sym_cnt_r <= '0;
      else if (symbol_valid) sym_cnt_r <= sym_cnt_r + 1'b1;
    end
  end

  // Write channel: address and data are taken together in one beat
  logic              wr_go;
  logic              rd_go;
  logic              wr_cfg;
  logic              wr_map;
  logic              cap_go;
  logic [PAIR_W-1:0] wr_pair;
  logic              rd_mse;
  logic              rd_qual;
  logic              rd_map;
  logic [2:0]        th_sel;
  logic [2:0]        rd_th_sel;
  logic              wr_th;
  logic              rd_th;

  assign wr_go     = ce && s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rd_go     = ce && s_axi_arvalid && !rvalid_r;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign th_sel    = 3'(s_axi_awaddr[AXI_AW-1:2] - OFS_THRESH[AXI_AW-1:2]);
  assign rd_th_sel = 3'(s_axi_araddr[AXI_AW-1:2] - OFS_THRESH[AXI_AW-1:2]);
  assign wr_th     = s_axi_awaddr >= OFS_THRESH && s_axi_awaddr < OFS_THRESH + 8'h10;
  assign rd_th     = s_axi_araddr >= OFS_THRESH && s_axi_araddr < OFS_THRESH + 8'h10;
  assign wr_cfg    = wr_go && s_axi_awaddr[AXI_AW-1:2] == OFS_CONFIG[AXI_AW-1:2];
  assign wr_map    = (s_axi_awaddr[AXI_AW-1:2] == OFS_CONFIG[AXI_AW-1:2]) || wr_th;
  assign wr_pair   = s_axi_wdata[CFG_PAIR_LSB +: PAIR_W];
  // Capture is refused for pairs that do not exist and while measurement is off
  assign cap_go    = wr_cfg && s_axi_wstrb[0] && s_axi_wdata[CFG_CAPTURE] && enable_r
                     && (int'(wr_pair) < NUM_PAIRS);
  assign rd_mse    = rd_go && s_axi_araddr == OFS_MSE;
  assign rd_qual   = rd_go && s_axi_araddr == OFS_QUALITY;
  assign rd_map    = (s_axi_araddr[AXI_AW-1:5] == '0 && s_axi_araddr <= OFS_STATUS) || rd_th;

  // Per-pair filters and worst-case trackers
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    cqm_pair_if pif ();
    assign pif.enable     = enable_r;
    assign pif.sample_stb = symbol_valid;
    assign pif.tick       = tick;
    assign pif.gain       = gain_r;
    assign pif.scale      = scale_r;
    assign pif.cond_err   = condition(symbol_data[p*SAMPLE_W +: SAMPLE_W], speed_1000,
                                      square_r);
    assign cur_mse[p]     = pif.mse;
    assign cur_snap[p]    = pif.snap;
    assign cur_idx[p]     = quality_index(pif.mse, th_r);

    cqm_pair_filter u_filter (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .pif     (pif.filt)
    );

    logic restart_mse;
    logic restart_idx;
    assign restart_mse = rd_mse && pair_r == PAIR_W'(p);
    assign restart_idx = rd_qual && pair_r == PAIR_W'(p);

    // A new snapshot in a restart cycle is folded in next cycle, so none is lost
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wc_mse_r[p] <= '0;
        wc_idx_r[p] <= IDX_W'(NUM_THRESH - 1);
      end else if (ce) begin
        if (restart_mse || !enable_r) wc_mse_r[p] <= cur_mse[p];
        else if (cur_mse[p] > wc_mse_r[p]) wc_mse_r[p] <= cur_mse[p];
        if (restart_idx || !enable_r) wc_idx_r[p] <= cur_idx[p];
        else if (cur_idx[p] < wc_idx_r[p]) wc_idx_r[p] <= cur_idx[p];
      end
    end
  end

  // Configuration, thresholds and captured results
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_r     <= 1'b0;
      square_r     <= 1'b0;
      pair_r       <= '0;
      gain_r       <= GAIN_RST;
      scale_r      <= SCALE_RST;
      th_r         <= TH_RST;
      mse_res_r    <= '0;
      mse_wc_res_r <= '0;
      idx_res_r    <= '0;
      idx_wc_res_r <= '0;
      mean_res_r   <= '0;
    end else if (ce) begin
      if (wr_cfg && s_axi_wstrb[0]) begin
        enable_r <= s_axi_wdata[CFG_ENABLE];
        square_r <= s_axi_wdata[CFG_SQUARE];
        pair_r   <= wr_pair;
      end
      if (wr_cfg && s_axi_wstrb[1]) begin
        gain_r  <= s_axi_wdata[CFG_GAIN_LSB +: 4];
        scale_r <= s_axi_wdata[CFG_SCALE_LSB +: 4];
      end
      if (wr_go && wr_th) begin
        if (s_axi_wstrb[0] && s_axi_wstrb[1]) th_r[2*th_sel[1:0]]   <= s_axi_wdata[MSE_W-1:0];
        if (s_axi_wstrb[2] && s_axi_wstrb[3]) th_r[2*th_sel[1:0]+1] <=
          s_axi_wdata[TH_HI_LSB +: MSE_W];
      end
      if (cap_go) begin
        if (square_r) begin
          mse_res_r    <= cur_mse[wr_pair];
          mse_wc_res_r <= wc_mse_r[wr_pair];
          idx_res_r    <= cur_idx[wr_pair];
          idx_wc_res_r <= wc_idx_r[wr_pair];
        end else begin
          mean_res_r   <= cur_snap[wr_pair];
        end
      end
    end
  end

  // Response channels
  logic [31:0] rd_word;
  assign rd_word =
    (s_axi_araddr == OFS_CONFIG)   ? {16'h0000, scale_r, gain_r, 2'b00, 2'(pair_r), 2'b00,
                                      square_r, enable_r} :
    (s_axi_araddr == OFS_MSE)      ? 32'(mse_res_r) :
    (s_axi_araddr == OFS_MSE_WC)   ? 32'(mse_wc_res_r) :
    (s_axi_araddr == OFS_QUALITY)  ? 32'({idx_wc_res_r, 1'b0, idx_res_r}) :
    (s_axi_araddr == OFS_MEAN_ERR) ? 32'(mean_res_r) :
    (s_axi_araddr == OFS_STATUS)   ? 32'(sym_cnt_r) :
    rd_th ? {7'h00, th_r[2*rd_th_sel[1:0]+1], 7'h00, th_r[2*rd_th_sel[1:0]]} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rresp_r  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        rdata_r  <= rd_map ? rd_word : 32'h0000_0000;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;
endmodule
`default_nettype wire

// ===== sim/cqm_monitor_properties.sv
`timescale 1ns/100ps
`default_nettype none
module cqm_monitor_properties
  import cqm_pkg::*;
#(
  parameter int NUM_PAIRS  = 4,
  parameter int SNAP_COUNT = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              ce,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rready
);
  // Address of the read in flight, so read data can be judged by register
  logic [AXI_AW-1:0] rd_addr_r;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rd_addr_r <= '0;
    else if (s_axi_arvalid && s_axi_arready)
      rd_addr_r <= s_axi_araddr;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wr_answer; s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  property p_b_hold; s_axi_bvalid && !(s_axi_bready && ce) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_wr_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wr_block: assert property (p_wr_block) else $error("write taken during response");
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_r_hold; s_axi_rvalid && !(s_axi_rready && ce) |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_cap_clear; s_axi_rvalid && rd_addr_r == OFS_CONFIG |-> !s_axi_rdata[CFG_CAPTURE];
  endproperty
  a_cap_clear: assert property (p_cap_clear) else $error("capture bit not cleared");
  property p_mse_sat;
    s_axi_rvalid && (rd_addr_r == OFS_MSE || rd_addr_r == OFS_MSE_WC) |-> s_axi_rdata[31:9] == '0;
  endproperty
  a_mse_sat: assert property (p_mse_sat) else $error("mse above 511");
  property p_qual_range;
    s_axi_rvalid && rd_addr_r == OFS_QUALITY |-> s_axi_rdata[31:7] == '0 && !s_axi_rdata[3];
  endproperty
  a_qual_range: assert property (p_qual_range) else $error("quality out of range");
  property p_mean_lim; s_axi_rvalid && rd_addr_r == OFS_MEAN_ERR |-> s_axi_rdata <= ERR_MAX_100;
  endproperty
  a_mean_lim: assert property (p_mean_lim) else $error("mean error above limit");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_quality: cover property (s_axi_rvalid && rd_addr_r == OFS_QUALITY);
  c_mean: cover property (s_axi_rvalid && rd_addr_r == OFS_MEAN_ERR);
endmodule

bind cqm_monitor cqm_monitor_properties #(.NUM_PAIRS(NUM_PAIRS), .SNAP_COUNT(SNAP_COUNT))
  u_cqm_monitor_properties (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rready(s_axi_rready));
`default_nettype wire

// ===== sim/test_channel_quality_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module test_channel_quality_monitor
  import cqm_pkg::*;
;
  localparam int          NP      = 4;
  localparam int          SNAP    = 8;
  localparam logic [31:0] CFG_RST = {16'h0, SCALE_RST, GAIN_RST, 8'h00};
  logic                   aclk    = 1'b0;
  logic                   aresetn = 1'b0;
  logic                   sym_valid = 1'b0;
  logic                   spd     = 1'b0;
  logic                   ce      = 1'b1;
  logic [31:0]            rd_d;
  logic [1:0]             rd_r;
  logic [NP*SAMPLE_W-1:0] sym_data = '0;
  logic [AXI_AW-1:0]      awaddr  = '0;
  logic [AXI_AW-1:0]      araddr  = '0;
  logic [31:0]            wdata   = '0;
  logic [3:0]             wstrb   = '0;
  logic                   awvalid = 1'b0;
  logic                   wvalid  = 1'b0;
  logic                   bready  = 1'b0;
  logic                   arvalid = 1'b0;
  logic                   rready  = 1'b0;
  logic                   awready, wready, bvalid, arready, rvalid;
  logic [1:0]             bresp, rresp;
  logic [31:0]            rdata;
  int                     err_total = 0;
  int                     check_count = 0;
  int                     cycles  = 0;
  int                     lv1[NP] = '{5, -140, 30, 64};
  int                     lv2[NP] = '{40, 96, -10, 200};
  int                     lv3[NP] = '{37, -140, 30, 64};
  int                     m1[NP], m2[NP], i1[NP], i2[NP];

  always #50 aclk = ~aclk;

  cqm_monitor #(.NUM_PAIRS(NP), .SNAP_COUNT(SNAP)) u_cqm_monitor (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .symbol_valid(sym_valid),
    .symbol_data(sym_data), .speed_1000(spd), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(n, e, d);
    chk(n, {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  // Reference slicer: ties at a decision point go to the inner level
  function automatic int cond_err(int l, logic fast);
    int rf;
    int e;
    if (fast)
      rf = l > 96 ? 128 : l > 32 ? 64 : l >= -32 ? 0 : l >= -96 ? -64 : -128;
    else
      rf = l > 64 ? 128 : l >= -64 ? 0 : -128;
    e = l > rf ? l - rf : rf - l;
    if (fast)
      return (e > ERR_MAX_1000 ? ERR_MAX_1000 : e) * 2;
    return e > ERR_MAX_100 ? ERR_MAX_100 : e;
  endfunction

  function automatic int mse_of(int e);
    int v;
    v = (e * e) >> 3;
    return v > 511 ? 511 : v;
  endfunction

  function automatic int idx_of(int m);
    int k;
    k = 0;
    for (int n = 1; n <= 7; n++)
      if (m <= TH_RST[n-1]) k = n;
    return k;
  endfunction

  // Enabled, output scale 3, chosen gain
  function automatic logic [31:0] cfg(logic sq, logic cap, int p, logic [3:0] g);
    return {16'h0, 4'h3, g, 2'h0, p[1:0], 1'b0, cap, sq, 1'b1};
  endfunction

  task automatic stream(input logic fast, input int lv[NP]);
    @(posedge aclk);
    spd <= fast;
    for (int p = 0; p < NP; p++)
      sym_data[p*SAMPLE_W +: SAMPLE_W] <= lv[p][SAMPLE_W-1:0];
    sym_valid <= 1'b1;
    repeat (3 * SNAP) @(posedge aclk);
    sym_valid <= 1'b0;
  endtask

  task automatic check_pair(input int p, input int m, input int wm, input int q, input int wq);
    wr(OFS_CONFIG, cfg(1'b1, 1'b1, p, 4'h0), 4'hF, RESP_OKAY);
    rchk(OFS_MSE, m, "mse");
    rchk(OFS_MSE_WC, wm, "mse worst");
    rchk(OFS_QUALITY, wq * 16 + q, "quality");
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(OFS_CONFIG, CFG_RST, "config reset");
    for (int k = 0; k < 4; k++)
      rchk(OFS_THRESH + 8'(4 * k), {7'h0, TH_RST[2*k+1], 7'h0, TH_RST[2*k]}, "threshold");
    wr(8'h44, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    rchk(OFS_CONFIG, CFG_RST, "config after unmapped write");
    rd(8'h44, rd_d, rd_r);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rd_r});
    chk("unmapped rdata", 32'h0000_0000, rd_d);
    $display("test reset and map done");
    // Symbols arriving while disabled must leave the filters at zero
    stream(1'b0, lv1);
    wr(OFS_CONFIG, cfg(1'b1, 1'b0, 2, 4'h0), 4'hF, RESP_OKAY);
    check_pair(2, 0, 0, 7, 7);
    $display("test disabled done");
    stream(1'b0, lv1);
    for (int p = 0; p < NP; p++) begin
      m1[p] = mse_of(cond_err(lv1[p], 1'b0));
      i1[p] = idx_of(m1[p]);
      check_pair(p, m1[p], m1[p], i1[p], i1[p]);
    end
    $display("test slow square done");
    stream(1'b1, lv2);
    for (int p = 0; p < NP; p++) begin
      m2[p] = mse_of(cond_err(lv2[p], 1'b1));
      i2[p] = idx_of(m2[p]);
      check_pair(p, m2[p], m1[p] > m2[p] ? m1[p] : m2[p], i2[p], i1[p] < i2[p] ? i1[p] : i2[p]);
      wr(OFS_CONFIG, cfg(1'b1, 1'b1, p, 4'h0), 4'hF, RESP_OKAY);
      rchk(OFS_MSE_WC, m2[p], "mse worst restarted");
      rchk(OFS_QUALITY, i2[p] * 17, "quality restarted");
    end
    $display("test fast square done");
    wr(OFS_CONFIG, cfg(1'b0, 1'b0, 0, 4'h0), 4'hF, RESP_OKAY);
    stream(1'b0, lv1);
    for (int p = 0; p < NP; p++) begin
      wr(OFS_CONFIG, cfg(1'b0, 1'b1, p, 4'h0), 4'hF, RESP_OKAY);
      rchk(OFS_MEAN_ERR, cond_err(lv1[p], 1'b0), "mean error");
    end
    rchk(OFS_MSE, m2[3], "mse kept in absolute mode");
    // Gain 1 halves each step, so the integer part stays one short of the target
    wr(OFS_CONFIG, cfg(1'b0, 1'b0, 0, 4'h1), 4'hF, RESP_OKAY);
    stream(1'b0, lv3);
    wr(OFS_CONFIG, cfg(1'b0, 1'b1, 0, 4'h1), 4'hF, RESP_OKAY);
    rchk(OFS_MEAN_ERR, 36, "mean error gain 1");
    // Clock enable low: symbols must not move the filter or the snapshot
    ce <= 1'b0;
    stream(1'b0, lv1);
    ce <= 1'b1;
    wr(OFS_CONFIG, cfg(1'b0, 1'b1, 0, 4'h1), 4'hF, RESP_OKAY);
    rchk(OFS_MEAN_ERR, 36, "mean error frozen");
    $display("test absolute done");
    wr(OFS_THRESH + 8'h04, 32'h0055_0066, 4'h3, RESP_OKAY);
    rchk(OFS_THRESH + 8'h04, {7'h0, TH_RST[3], 16'h0066}, "threshold partial");
    $display("test threshold write done");
    conclude();
  end
endmodule
`default_nettype wire
